/* File: adsl_pkg.sv */
// Shared constants and types for the serial register access block
`default_nettype none
package adsl_pkg;
	localparam logic [4:0] ADDR_CH0_FIRST = 5'h00;
	localparam logic [4:0] ADDR_CH0_LOW = 5'h02;
	localparam logic [4:0] ADDR_CH1_FIRST = 5'h03;
	localparam logic [4:0] ADDR_CH1_LOW = 5'h05;
	localparam logic [4:0] ADDR_BITSTREAM = 5'h06;
	localparam logic [4:0] ADDR_DELAY_HI = 5'h07;
	localparam logic [4:0] ADDR_DELAY_LO = 5'h08;
	localparam logic [4:0] ADDR_STATUS = 5'h0A;
	localparam logic [4:0] ADDR_CONFIG_HI = 5'h0C;
	localparam logic [4:0] ADDR_CONFIG_LO = 5'h0D;
	localparam logic [4:0] ADDR_MAP_LAST = 5'h1A;
	localparam logic [4:0] GRP_A_END = 5'h02;
	localparam logic [4:0] GRP_B_END = 5'h05;
	localparam logic [4:0] GRP_C_END = 5'h09;
	localparam logic [4:0] GRP_D_END = 5'h0D;
	localparam logic [4:0] GRP_E_END = 5'h13;
	localparam logic [4:0] GRP_F_END = 5'h19;
	localparam logic [4:0] TYPE_DATA_END = 5'h05;

	localparam int STAT_LOOP_POS = 6;
	localparam int STAT_AUTOSTEP_POS = 5;
	localparam int STAT_WIDTH_POS = 3;
	localparam int STAT_SOURCE_POS = 1;
	localparam int STAT_IDLE_POS = 0;
	localparam int CFG_HOLD_POS = 6;
	localparam int CFG_SLEEP_POS = 4;
	localparam int CFG_OSR_POS = 5;
	localparam int CFG_DIV_POS = 3;
	localparam int CFG_EXTCLK_POS = 2;
	localparam int CFG_EXTREF_POS = 1;
	localparam int CFG_BITOUT_POS = 0;
	localparam logic [7:0] CFG_RESTART_MASK = 8'hFF;

	localparam logic [7:0] RST_BITSTREAM = 8'h33;
	localparam logic [7:0] RST_STATUS = 8'hB9;
	localparam logic [7:0] RST_OTHER = 8'h00;

	localparam logic [1:0] WIDTH_BOTH16 = 2'b00;
	localparam logic [1:0] WIDTH_BOTH24 = 2'b11;

	typedef enum logic [1:0] {
		LOOP_FIXED = 2'b00,
		LOOP_GROUP = 2'b01,
		LOOP_TYPE = 2'b10,
		LOOP_MAP = 2'b11
	} adsl_loop_t;

	typedef enum logic [1:0] {
		SRC_LINKED = 2'b00,
		SRC_FIRST = 2'b01,
		SRC_SECOND = 2'b10,
		SRC_BOTH = 2'b11
	} adsl_src_t;

	typedef enum logic [1:0] {
		PH_IDLE = 2'b00,
		PH_CTRL = 2'b01,
		PH_READ = 2'b10,
		PH_WRITE = 2'b11
	} adsl_phase_t;

	typedef struct packed {
		logic csN;
		logic sck;
		logic sdi;
	} adsl_serial_t;

	typedef struct packed {
		logic [1:0] hold;
		logic [1:0] sleep;
		logic [2:0] oversample_ratio;
		logic [1:0] divider;
		logic extClk;
		logic extRef;
		logic bitOut;
		logic [15:0] delay;
	} adsl_conv_cfg_t;
endpackage : adsl_pkg
`default_nettype wire

/* File: adsl_addr_step.sv */
// Read address counter step: loop sets and short-channel byte skipping
`default_nettype none
module adsl_addr_step (
	input wire logic [4:0] addr,
	input wire adsl_pkg::adsl_loop_t loopSel,
	input wire logic [1:0] widthSel,
	output logic [4:0] nextAddr
);
	logic [4:0] grpLo;
	logic [4:0] grpHi;
	logic [4:0] setLo;
	logic [4:0] setHi;
	logic [4:0] first;
	logic [4:0] second;
	logic skipFirst;
	logic typeData;

	assign typeData = addr <= adsl_pkg::TYPE_DATA_END;
	assign grpHi = addr <= adsl_pkg::GRP_A_END ? adsl_pkg::GRP_A_END :
		addr <= adsl_pkg::GRP_B_END ? adsl_pkg::GRP_B_END :
		addr <= adsl_pkg::GRP_C_END ? adsl_pkg::GRP_C_END :
		addr <= adsl_pkg::GRP_D_END ? adsl_pkg::GRP_D_END :
		addr <= adsl_pkg::GRP_E_END ? adsl_pkg::GRP_E_END :
		addr <= adsl_pkg::GRP_F_END ? adsl_pkg::GRP_F_END : adsl_pkg::ADDR_MAP_LAST;
	assign grpLo = addr <= adsl_pkg::GRP_A_END ? adsl_pkg::ADDR_CH0_FIRST :
		addr <= adsl_pkg::GRP_B_END ? 5'(adsl_pkg::GRP_A_END + 5'h01) :
		addr <= adsl_pkg::GRP_C_END ? 5'(adsl_pkg::GRP_B_END + 5'h01) :
		addr <= adsl_pkg::GRP_D_END ? 5'(adsl_pkg::GRP_C_END + 5'h01) :
		addr <= adsl_pkg::GRP_E_END ? 5'(adsl_pkg::GRP_D_END + 5'h01) :
		addr <= adsl_pkg::GRP_F_END ? 5'(adsl_pkg::GRP_E_END + 5'h01) :
		adsl_pkg::ADDR_MAP_LAST;

	always_comb begin
		case (loopSel)
			adsl_pkg::LOOP_GROUP: begin
				setLo = grpLo;
				setHi = grpHi;
			end
			adsl_pkg::LOOP_TYPE: begin
				setLo = typeData ? adsl_pkg::ADDR_CH0_FIRST : adsl_pkg::ADDR_BITSTREAM;
				setHi = typeData ? adsl_pkg::TYPE_DATA_END : adsl_pkg::ADDR_MAP_LAST;
			end
			default: begin
				setLo = adsl_pkg::ADDR_CH0_FIRST;
				setHi = adsl_pkg::ADDR_MAP_LAST;
			end
		endcase
	end

	// Wrap inside the current set rather than leaving it
	assign first = addr == setHi ? setLo : 5'(addr + 5'h01);
	assign second = first == setHi ? setLo : 5'(first + 5'h01);
	assign skipFirst = (first == adsl_pkg::ADDR_CH0_LOW && widthSel == adsl_pkg::WIDTH_BOTH16) ||
		(first == adsl_pkg::ADDR_CH1_LOW && widthSel != adsl_pkg::WIDTH_BOTH24);
	assign nextAddr = loopSel == adsl_pkg::LOOP_FIXED ? addr : (skipFirst ? second : first);
endmodule : adsl_addr_step
`default_nettype wire

/* File: adsl_spi_core.sv */
// Serial register access, data latches and conversion-done strobe
`default_nettype none

module adsl_spi_core #(
	parameter logic [1:0] DEVICE_ADDR = 2'b00
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic hardResetN,
	input wire adsl_pkg::adsl_serial_t serialIn,
	input wire logic [23:0] firstResult,
	input wire logic [23:0] secondResult,
	input wire logic [1:0] chanReady,
	input wire logic decimatorTick,
	output logic sdoOut,
	output logic sdoOe,
	output logic strobeOut,
	output logic strobeOe,
	output adsl_pkg::adsl_conv_cfg_t convCfg,
	output logic convRestart
);
	logic clr;
	logic csPrev;
	logic sckPrev;
	logic csActive;
	logic csStart;
	logic csEnd;
	logic sckRise;
	logic sckFall;
	logic idleLow;

	adsl_pkg::adsl_phase_t phase;
	logic [2:0] bitCnt;
	logic [7:0] shiftIn;
	logic [7:0] nextIn;
	logic [7:0] shiftOut;
	logic [4:0] curAddr;
	logic pendLoad;
	logic awaitFresh;
	logic byteDone;
	logic ctrlDone;
	logic ctrlMatch;
	logic sdoOeNext;

	logic [7:0] cfgMem [6:26];
	logic [7:0] statusByte;
	adsl_pkg::adsl_loop_t loopSel;
	adsl_pkg::adsl_src_t srcSel;
	logic [1:0] widthSel;
	logic autoStep;
	logic idleDrive;
	logic [4:0] readStep;
	logic [4:0] writeStep;
	logic addrDefined;
	logic wrEn;

	logic isData;
	logic chSel;
	logic [1:0] byteIdx;
	logic [1:0] lastIdx;
	logic [1:0] wide;
	logic [23:0] stage1 [2];
	logic [23:0] frozen [2];
	logic [1:0] busy;
	logic [23:0] newResult [2];
	logic [23:0] dataWord;
	logic [7:0] dataByte;
	logic [4:0] cfgIdx;
	logic [7:0] readByte;
	logic loadFall;
	logic refresh;

	logic [1:0] seen;
	logic jointFire;
	logic [1:0] capture;
	logic strobeEvent;
	logic pulsing;
	logic next_pulsing;
	logic restartReq;
	adsl_pkg::adsl_conv_cfg_t next_cfg;

	// The hard reset pin acts like the reset input
	assign clr = rst | ~hardResetN;

	assign csActive = ~serialIn.csN;
	assign csStart = csActive & csPrev;
	assign csEnd = serialIn.csN & ~csPrev;
	assign sckRise = csActive & serialIn.sck & ~sckPrev;
	assign sckFall = csActive & ~serialIn.sck & sckPrev;

	always_ff @(posedge clk_sys) begin
		csPrev <= clr ? 1'b1 : serialIn.csN;
		sckPrev <= clr ? 1'b0 : serialIn.sck;
	end

	// Idle level at selection tells the two clock modes apart
	always_ff @(posedge clk_sys) begin
		if (clr) begin
			idleLow <= 1'b1;
		end else if (csStart) begin
			idleLow <= ~serialIn.sck;
		end
	end

	assign nextIn = {shiftIn[6:0], serialIn.sdi};
	assign byteDone = sckRise && bitCnt == 3'd7;
	assign ctrlDone = byteDone && phase == adsl_pkg::PH_CTRL;
	// Device address sits in the two bits sent first
	assign ctrlMatch = nextIn[7:6] == DEVICE_ADDR;

	always_ff @(posedge clk_sys) begin
		if (clr || csStart) begin
			bitCnt <= 3'd0;
			shiftIn <= 8'h00;
		end else if (sckRise) begin
			bitCnt <= 3'(bitCnt + 3'd1);
			shiftIn <= nextIn;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (clr || csEnd) begin
			phase <= adsl_pkg::PH_IDLE;
		end else if (csStart) begin
			phase <= adsl_pkg::PH_CTRL;
		end else if (ctrlDone) begin
			phase <= !ctrlMatch ? adsl_pkg::PH_IDLE :
				(nextIn[0] ? adsl_pkg::PH_READ : adsl_pkg::PH_WRITE);
		end
	end

	// Status and communication byte fields
	assign statusByte = cfgMem[adsl_pkg::ADDR_STATUS];
	assign loopSel = adsl_pkg::adsl_loop_t'(statusByte[adsl_pkg::STAT_LOOP_POS +: 2]);
	assign srcSel = adsl_pkg::adsl_src_t'(statusByte[adsl_pkg::STAT_SOURCE_POS +: 2]);
	assign widthSel = statusByte[adsl_pkg::STAT_WIDTH_POS +: 2];
	assign autoStep = statusByte[adsl_pkg::STAT_AUTOSTEP_POS];
	assign idleDrive = statusByte[adsl_pkg::STAT_IDLE_POS];

	adsl_addr_step stepper (
		.addr(curAddr),
		.loopSel(loopSel),
		.widthSel(widthSel),
		.nextAddr(readStep)
	);

	assign addrDefined = curAddr <= adsl_pkg::ADDR_MAP_LAST;
	assign writeStep = curAddr == adsl_pkg::ADDR_MAP_LAST ? adsl_pkg::ADDR_BITSTREAM :
		5'(curAddr + 5'h01);
	assign wrEn = byteDone && phase == adsl_pkg::PH_WRITE && addrDefined &&
		curAddr >= adsl_pkg::ADDR_BITSTREAM;

	// Undefined addresses neither store nor advance the counter in a write; reads still step past them
	always_ff @(posedge clk_sys) begin
		if (clr) begin
			curAddr <= adsl_pkg::ADDR_CH0_FIRST;
		end else if (ctrlDone) begin
			curAddr <= nextIn[5:1];
		end else if (byteDone && phase == adsl_pkg::PH_READ) begin
			curAddr <= readStep;
		end else if (byteDone && phase == adsl_pkg::PH_WRITE && addrDefined && autoStep) begin
			curAddr <= writeStep;
		end
	end

	// Configuration bytes, one register per address
	generate
		for (genvar i = 6; i <= 26; i++) begin : g_cfg
			localparam logic [7:0] RESET_VAL = i == 6 ? adsl_pkg::RST_BITSTREAM :
				(i == 10 ? adsl_pkg::RST_STATUS : adsl_pkg::RST_OTHER);
			always_ff @(posedge clk_sys) begin
				if (clr) begin
					cfgMem[i] <= RESET_VAL;
				end else if (wrEn && curAddr == 5'(i)) begin
					cfgMem[i] <= nextIn;
				end
			end
		end
	endgenerate

	// Read path
	assign isData = curAddr <= adsl_pkg::TYPE_DATA_END;
	assign chSel = curAddr >= adsl_pkg::ADDR_CH1_FIRST;
	assign byteIdx = chSel ? 2'(curAddr - adsl_pkg::ADDR_CH1_FIRST) : curAddr[1:0];
	assign wide[0] = widthSel != adsl_pkg::WIDTH_BOTH16;
	assign wide[1] = widthSel == adsl_pkg::WIDTH_BOTH24;
	assign lastIdx = wide[chSel] ? 2'd2 : 2'd1;
	assign dataWord = busy[chSel] ? frozen[chSel] : stage1[chSel];
	assign dataByte = byteIdx == 2'd0 ? dataWord[23:16] :
		(byteIdx == 2'd1 ? dataWord[15:8] : dataWord[7:0]);
	assign cfgIdx = (isData || !addrDefined) ? adsl_pkg::ADDR_BITSTREAM : curAddr;
	assign readByte = isData ? dataByte : (addrDefined ? cfgMem[cfgIdx] : 8'h00);

	assign loadFall = sckFall && phase == adsl_pkg::PH_READ && pendLoad;
	assign refresh = awaitFresh && capture[chSel] && !sckFall;
	assign newResult[0] = firstResult;
	assign newResult[1] = secondResult;

	// Output shifts on falling edges or an idle-low result refresh, so idle-high mode simply holds the LSB
	always_ff @(posedge clk_sys) begin
		if (clr || csStart) begin
			sdoOut <= 1'b0;
			shiftOut <= 8'h00;
		end else if (loadFall) begin
			sdoOut <= readByte[7];
			shiftOut <= {readByte[6:0], 1'b0};
		end else if (sckFall && phase == adsl_pkg::PH_READ) begin
			sdoOut <= shiftOut[7];
			shiftOut <= {shiftOut[6:0], 1'b0};
		end else if (refresh) begin
			sdoOut <= newResult[chSel][23];
			shiftOut <= {newResult[chSel][22:16], 1'b0};
		end
	end

	always_ff @(posedge clk_sys) begin
		if (clr || csEnd) begin
			pendLoad <= 1'b0;
		end else if ((ctrlDone && ctrlMatch && nextIn[0]) ||
			(byteDone && phase == adsl_pkg::PH_READ)) begin
			pendLoad <= 1'b1;
		end else if (loadFall) begin
			pendLoad <= 1'b0;
		end
	end

	// Idle-low mode waits with the first data bit for the next result
	always_ff @(posedge clk_sys) begin
		if (clr || csEnd || sckRise) begin
			awaitFresh <= 1'b0;
		end else if (loadFall) begin
			awaitFresh <= idleLow && isData && byteIdx == 2'd0;
		end
	end

	// Mirrors the read state of the phase register without extra lag
	assign sdoOeNext = !csEnd && !csStart &&
		(ctrlDone ? (ctrlMatch && nextIn[0]) : phase == adsl_pkg::PH_READ);

	always_ff @(posedge clk_sys) begin
		sdoOe <= clr ? 1'b0 : sdoOeNext;
	end

	// Capture events: linked mode waits for the lagging channel
	assign jointFire = srcSel == adsl_pkg::SRC_LINKED && (seen | chanReady) == 2'b11;
	assign capture = srcSel == adsl_pkg::SRC_LINKED ? {2{jointFire}} : chanReady;

	always_ff @(posedge clk_sys) begin
		if (clr || jointFire || srcSel != adsl_pkg::SRC_LINKED) begin
			seen <= 2'b00;
		end else begin
			seen <= seen | chanReady;
		end
	end

	generate
		for (genvar c = 0; c < 2; c++) begin : g_chan
			always_ff @(posedge clk_sys) begin
				if (clr) begin
					stage1[c] <= 24'h000000;
				end else if (capture[c]) begin
					stage1[c] <= newResult[c];
				end
			end

			// Frozen copy lives until the channel's last byte is clocked out
			always_ff @(posedge clk_sys) begin
				if (clr || csEnd) begin
					busy[c] <= 1'b0;
					frozen[c] <= 24'h000000;
				end else if (loadFall && isData && chSel == 1'(c) && !busy[c]) begin
					busy[c] <= 1'b1;
					frozen[c] <= stage1[c];
				end else if (refresh && chSel == 1'(c)) begin
					frozen[c] <= newResult[c];
				end else if (byteDone && phase == adsl_pkg::PH_READ && isData &&
					chSel == 1'(c) && byteIdx == lastIdx) begin
					busy[c] <= 1'b0;
				end
			end
		end
	endgenerate

	// Strobe source and pulse width
	always_comb begin
		case (srcSel)
			adsl_pkg::SRC_FIRST: strobeEvent = chanReady[0];
			adsl_pkg::SRC_SECOND: strobeEvent = chanReady[1];
			adsl_pkg::SRC_BOTH: strobeEvent = |chanReady;
			default: strobeEvent = jointFire;
		endcase
	end

	// Chip select plays no part here, so strobes run between transfers
	assign next_pulsing = strobeEvent ? 1'b1 : (decimatorTick ? 1'b0 : pulsing);

	always_ff @(posedge clk_sys) begin
		if (clr) begin
			pulsing <= 1'b0;
			strobeOut <= 1'b1;
			strobeOe <= 1'b0;
		end else begin
			pulsing <= next_pulsing;
			strobeOut <= ~next_pulsing;
			strobeOe <= next_pulsing | idleDrive;
		end
	end

	// Converter control; any delay write restarts, even with the same value
	assign restartReq = wrEn && (curAddr == adsl_pkg::ADDR_DELAY_HI ||
		curAddr == adsl_pkg::ADDR_DELAY_LO ||
		(curAddr == adsl_pkg::ADDR_CONFIG_HI &&
		((nextIn ^ cfgMem[adsl_pkg::ADDR_CONFIG_HI]) & adsl_pkg::CFG_RESTART_MASK) != 8'h00));

	assign next_cfg.hold = cfgMem[adsl_pkg::ADDR_CONFIG_LO][adsl_pkg::CFG_HOLD_POS +: 2];
	assign next_cfg.sleep = cfgMem[adsl_pkg::ADDR_CONFIG_LO][adsl_pkg::CFG_SLEEP_POS +: 2];
	assign next_cfg.oversample_ratio = cfgMem[adsl_pkg::ADDR_CONFIG_HI][adsl_pkg::CFG_OSR_POS +: 3];
	assign next_cfg.divider = cfgMem[adsl_pkg::ADDR_CONFIG_HI][adsl_pkg::CFG_DIV_POS +: 2];
	assign next_cfg.extClk = cfgMem[adsl_pkg::ADDR_CONFIG_HI][adsl_pkg::CFG_EXTCLK_POS];
	assign next_cfg.extRef = cfgMem[adsl_pkg::ADDR_CONFIG_HI][adsl_pkg::CFG_EXTREF_POS];
	assign next_cfg.bitOut = cfgMem[adsl_pkg::ADDR_CONFIG_HI][adsl_pkg::CFG_BITOUT_POS];
	assign next_cfg.delay = {cfgMem[adsl_pkg::ADDR_DELAY_HI], cfgMem[adsl_pkg::ADDR_DELAY_LO]};

	always_ff @(posedge clk_sys) begin
		if (clr) begin
			convCfg <= '0;
			convRestart <= 1'b0;
		end else begin
			convCfg <= next_cfg;
			convRestart <= restartReq;
		end
	end
endmodule : adsl_spi_core
`default_nettype wire

/* File: adsl_host_model.sv */
// Host serial controller model for both clock idle levels
`default_nettype none
module adsl_host_model (
	input wire logic clk_sys,
	input wire logic sdoOut,
	output var adsl_pkg::adsl_serial_t serialOut
);
	timeunit 1ns;
	timeprecision 1ns;
	// Each clock level spans several samples of the system clock
	localparam int HALF = 4;
	logic idleHigh = 1'b0;
	initial serialOut = '{csN: 1'b1, sck: 1'b0, sdi: 1'b1};

	task automatic wait_cyc(input int n);
		repeat (n) @(negedge clk_sys);
	endtask : wait_cyc

	task automatic open_frame(input logic mode11);
		idleHigh = mode11;
		serialOut.sck = mode11; // Clock level settles before select
		wait_cyc(HALF);
		serialOut.csN = 1'b0;
		wait_cyc(HALF);
	endtask : open_frame

	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--) begin
			serialOut.sck = 1'b0;
			serialOut.sdi = tx[i];
			wait_cyc(HALF);
			rx[i] = sdoOut;
			serialOut.sck = 1'b1; // Data taken by the device on this rise
			wait_cyc(HALF);
		end
	endtask : xfer

	task automatic park();
		if (!idleHigh) serialOut.sck = 1'b0; // Idle-low clock rests low
		wait_cyc(HALF);
	endtask : park

	task automatic close_frame();
		park();
		serialOut.csN = 1'b1; // Only now does the address loop end
		serialOut.sdi = ~serialOut.sdi; // Released line shows no stale level
		wait_cyc(2 * HALF);
	endtask : close_frame
endmodule : adsl_host_model
`default_nettype wire

/* File: adsl_spi_core_asserts.sv */
// Port-level assertions for the serial access block
`default_nettype none
module adsl_spi_core_asserts (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic hardResetN,
	input wire adsl_pkg::adsl_serial_t serialIn,
	input wire logic [23:0] firstResult,
	input wire logic [23:0] secondResult,
	input wire logic [1:0] chanReady,
	input wire logic decimatorTick,
	input wire logic sdoOut,
	input wire logic sdoOe,
	input wire logic strobeOut,
	input wire logic strobeOe,
	input wire adsl_pkg::adsl_conv_cfg_t convCfg,
	input wire logic convRestart
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst || !hardResetN);

	sequence s_pulseLow;
		!strobeOut && !decimatorTick;
	endsequence
	sequence s_pulseEnd;
		!strobeOut && decimatorTick && chanReady == 2'b00;
	endsequence

	pin_reset_a: assert property (disable iff (rst) !hardResetN |=> !strobeOe && strobeOut)
		else $error("strobe active under hard reset");
	strobe_hold_a: assert property (s_pulseLow |=> !strobeOut)
		else $error("strobe ended before decimator tick");
	strobe_end_a: assert property (s_pulseEnd |=> strobeOut)
		else $error("strobe longer than one decimator period");
	strobe_drive_a: assert property (!strobeOut |-> strobeOe)
		else $error("strobe low but not driven");
	strobe_cause_a: assert property ($fell(strobeOut) |-> $past(chanReady) != 2'b00)
		else $error("strobe without conversion event");
	cs_quiet_a: assert property (serialIn.csN [*3] |-> !sdoOe)
		else $error("output driven while deselected");
	ctrl_first_a: assert property ($fell(serialIn.csN) |-> !sdoOe [*8])
		else $error("output driven during control byte");
	restart_frame_a: assert property (convRestart |-> !$past(serialIn.csN))
		else $error("restart outside a write");
	restart_pulse_a: assert property (convRestart |=> !convRestart)
		else $error("restart longer than one cycle");
endmodule : adsl_spi_core_asserts

bind adsl_spi_core adsl_spi_core_asserts adsl_spi_core_asserts_inst (.clk_sys(clk_sys),
	.rst(rst), .hardResetN(hardResetN), .serialIn(serialIn), .firstResult(firstResult),
	.secondResult(secondResult), .chanReady(chanReady), .decimatorTick(decimatorTick),
	.sdoOut(sdoOut), .sdoOe(sdoOe), .strobeOut(strobeOut), .strobeOe(strobeOe),
	.convCfg(convCfg), .convRestart(convRestart));
`default_nettype wire

/* File: testbench.sv */
// Self-checking bench for the serial access block
`default_nettype none
`define CHECK(g, e) begin \
	checks_done++; \
	if ((g) !== (e)) begin \
		n_fail++; \
		$display("unexpected at %0t: got %0h expected %0h", $time, g, e); \
	end \
end
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic hardResetN = 1'b1;
	adsl_pkg::adsl_serial_t serialIn;
	logic [23:0] firstResult = 24'h000000;
	logic [23:0] secondResult = 24'h000000;
	logic [1:0] chanReady = 2'b00;
	logic decimatorTick = 1'b0;
	logic [2:0] tickCnt = 3'h0;
	logic sdoOut, sdoOe, strobeOut, strobeOe, convRestart;
	adsl_pkg::adsl_conv_cfg_t convCfg;
	int n_fail = 0;
	int checks_done = 0;
	int nRestart = 0;
	int nFall = 0;
	logic prevStrobe = 1'b1;
	// Bench view of the latched codes and of the status byte
	logic [23:0] fr = 24'h000000;
	logic [23:0] sr = 24'h000000;
	logic [7:0] status = 8'hB9;
	logic [7:0] got [8];
	logic [7:0] lastExp;

	adsl_spi_core adsl_spi_core_inst (.clk_sys(clk_sys), .rst(rst), .hardResetN(hardResetN),
		.serialIn(serialIn), .firstResult(firstResult), .secondResult(secondResult),
		.chanReady(chanReady), .decimatorTick(decimatorTick), .sdoOut(sdoOut), .sdoOe(sdoOe),
		.strobeOut(strobeOut), .strobeOe(strobeOe), .convCfg(convCfg), .convRestart(convRestart));
	adsl_host_model adsl_host_model_inst (.clk_sys(clk_sys), .sdoOut(sdoOut), .serialOut(serialIn));

	initial begin
		forever #25 clk_sys = ~clk_sys;
	end
	always @(negedge clk_sys) begin
		tickCnt <= tickCnt + 3'h1;
		decimatorTick <= tickCnt == 3'h7;
	end
	always @(posedge clk_sys) begin
		prevStrobe <= strobeOut;
		if (prevStrobe === 1'b1 && strobeOut === 1'b0) nFall++;
		if (convRestart === 1'b1) nRestart++;
	end

	function automatic logic [7:0] val(input logic [4:0] a);
		logic [47:0] data;
		data = {fr, sr};
		if (a < 5'h06) return data[8 * (5 - a) +: 8];
		if (a == 5'h06) return 8'h33;
		if (a == adsl_pkg::ADDR_STATUS) return status;
		return 8'h00;
	endfunction : val

	// Only the sets this bench walks through are modelled
	function automatic logic [4:0] nxt(input logic [4:0] a);
		logic [4:0] lo, hi, b;
		lo = 5'h00;
		hi = 5'h1A;
		if (status[7:6] == 2'b00) return a;
		if (status[7:6] == 2'b01) begin
			lo = a < 5'h03 ? 5'h00 : 5'h03;
			hi = a < 5'h03 ? 5'h02 : 5'h05;
		end else if (status[7:6] == 2'b10 && a < 5'h06) hi = 5'h05;
		else if (status[7:6] == 2'b10) lo = 5'h06;
		b = a + 5'h01;
		if (b == 5'h02 && status[4:3] == 2'b00) b = 5'h03;
		if (b == 5'h05 && status[4:3] != 2'b11) b = 5'h06;
		return b > hi ? lo : b;
	endfunction : nxt

	task automatic wr(input logic [4:0] a, input logic [7:0] d [$]);
		logic [7:0] rx;
		adsl_host_model_inst.open_frame(1'b0);
		adsl_host_model_inst.xfer({2'b00, a, 1'b0}, rx);
		foreach (d[i]) adsl_host_model_inst.xfer(d[i], rx);
		`CHECK(sdoOe, 1'b0)
		adsl_host_model_inst.close_frame();
		if (a == adsl_pkg::ADDR_STATUS) status = d[0];
	endtask : wr

	task automatic rd(input logic [4:0] a, input int n, input logic m11, input logic keep);
		logic [4:0] e;
		e = a;
		adsl_host_model_inst.open_frame(m11);
		adsl_host_model_inst.xfer({2'b00, a, 1'b1}, got[0]);
		for (int i = 0; i < n; i++) begin
			adsl_host_model_inst.xfer(8'h00, got[i]);
			lastExp = val(e);
			`CHECK(got[i], lastExp)
			`CHECK(sdoOe, 1'b1)
			e = nxt(e);
		end
		if (m11) begin
			adsl_host_model_inst.wait_cyc(6);
			`CHECK(sdoOut, lastExp[0])
		end
		if (!keep) adsl_host_model_inst.close_frame();
	endtask : rd

	task automatic pulse(input logic [1:0] r);
		chanReady = r;
		@(negedge clk_sys);
		chanReady = 2'b00;
		repeat (12) @(negedge clk_sys);
	endtask : pulse

	task automatic stop_test();
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : stop_test

	initial begin
		repeat (90000) @(posedge clk_sys);
		n_fail++;
		stop_test();
	end

	initial begin
		repeat (10) @(negedge clk_sys);
		rst = 1'b0;
		repeat (4) @(negedge clk_sys);
		`CHECK(strobeOe, 1'b1)
		rd(5'h00, 7, 1'b0, 1'b0);
		rd(5'h06, 1, 1'b0, 1'b0);
		rd(adsl_pkg::ADDR_STATUS, 1, 1'b0, 1'b0);
		$display("test reset values done");
		firstResult = 24'hA1B2C3;
		secondResult = 24'hD4E5F6;
		pulse(2'b01);
		rd(5'h00, 1, 1'b0, 1'b0);
		pulse(2'b10);
		fr = firstResult;
		sr = secondResult;
		for (int w = 0; w < 4; w++) begin
			wr(adsl_pkg::ADDR_STATUS, '{{3'b101, w[1:0], 3'b001}});
			rd(5'h00, 7, w[0], 1'b0);
		end
		for (int l = 0; l < 4; l++) begin
			wr(adsl_pkg::ADDR_STATUS, '{{l[1:0], 6'b111001}});
			rd(5'h04, 4, 1'b0, 1'b0);
		end
		$display("test address loops done");
		wr(adsl_pkg::ADDR_STATUS, '{8'hB9});
		rd(5'h00, 6, 1'b0, 1'b1);
		adsl_host_model_inst.park();
		`CHECK(sdoOut, fr[23])
		firstResult = 24'h5A0000;
		pulse(2'b01);
		pulse(2'b10);
		`CHECK(sdoOut, firstResult[23])
		adsl_host_model_inst.close_frame();
		fr = firstResult;
		for (int s = 0; s < 4; s++) begin
			wr(adsl_pkg::ADDR_STATUS, '{{5'b10111, s[1:0], 1'b1}});
			nFall = 0;
			pulse(2'b01);
			pulse(2'b10);
			`CHECK(nFall, s == 3 ? 2 : 1)
		end
		wr(adsl_pkg::ADDR_STATUS, '{8'hB8});
		`CHECK(strobeOe, 1'b0)
		wr(adsl_pkg::ADDR_STATUS, '{8'hB9});
		$display("test strobe done");
		nRestart = 0;
		wr(adsl_pkg::ADDR_DELAY_HI, '{8'h00});
		`CHECK(nRestart, 1)
		wr(adsl_pkg::ADDR_CONFIG_LO, '{8'hC0});
		`CHECK(convCfg.hold, 2'b11)
		wr(adsl_pkg::ADDR_DELAY_HI, '{8'h12, 8'h34, 8'h00, 8'hB9, 8'h00, 8'h20, 8'h00});
		`CHECK(convCfg.delay, 16'h1234)
		`CHECK(convCfg.oversample_ratio, 3'b001)
		`CHECK(convCfg.hold, 2'b00)
		nRestart = 0;
		wr(adsl_pkg::ADDR_CONFIG_HI, '{8'h20});
		wr(adsl_pkg::ADDR_CONFIG_HI, '{8'h24});
		`CHECK(nRestart, 1)
		$display("test restart done");
		hardResetN = 1'b0;
		nFall = 0;
		pulse(2'b11);
		`CHECK(strobeOe, 1'b0)
		`CHECK(nFall, 0)
		hardResetN = 1'b1;
		repeat (4) @(negedge clk_sys);
		pulse(2'b11);
		`CHECK(nFall, 1)
		$display("test hard reset done");
		stop_test();
	end
endmodule : testbench
`default_nettype wire
